// *** shared/dtc_regs.svh ***
// Register map, field positions, reset values and timing counts
// Assumes inclusion by the converter control package and module
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH
`define DTC_OFS_CTRL 8'h00
`define DTC_OFS_HIGH 8'h04
`define DTC_OFS_LOW 8'h08
`define DTC_OFS_STAT 8'h0C
`define DTC_RST_CTRL 8'h00
`define DTC_RST_HIGH 8'h00
`define DTC_RST_LOW 8'h00
`define DTC_BIT_ENABLE 0
`define DTC_BIT_PIN_OE 1
`define DTC_BIT_LEFT_ADJ 2
`define DTC_BIT_RSVD 3
`define DTC_POS_TRIG_SEL 4
`define DTC_BIT_AUTO_TRIG 7
`define DTC_CLK_PERIOD_NS 100
`define DTC_CONV_TIME_NS 1000
`define DTC_CONV_CYCLES \
  ((`DTC_CONV_TIME_NS + `DTC_CLK_PERIOD_NS - 1) / `DTC_CLK_PERIOD_NS)
`endif

// *** shared/dtc_pkg.sv ***
// Types shared by the converter control block and its bench
// Assumes the register header is on the include path
`include "dtc_regs.svh"
package dtc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dtc_apb_req_type;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } dtc_apb_rsp_type;
  typedef struct packed {
    logic auto_trigger_enable;
    logic [2:0] trigger_select;
    logic rsvd;
    logic left_adjust;
    logic pin_output_enable;
    logic converter_enable;
  } dtc_ctrl_type;
  typedef struct packed {
    logic [9:0] code;
    logic enable;
    logic start;
    logic busy;
    logic analog_out_pin;
  } dtc_core_type;
  typedef enum logic [0:0] {
    DTC_IDLE = 1'h0,
    DTC_BUSY = 1'h1
  } dtc_conv_state_type;
endpackage : dtc_pkg

// *** rtl/dtc_ctrl.sv ***
// Converter control: APB registers, double buffer, trigger logic
// Assumes a synchronous APB master on mclk and level event flags
`timescale 1ns/1ns
`include "dtc_regs.svh"

// Function
// [R1] Enable bit gates conversions on/off
// [R2] Auto mode loads only on trigger edge
// [R3] Manual mode loads on high byte write
// [R4] Select field picks one of eight flags
// [R5] Select field ignored without auto mode
// [R6] Trigger is flag rise, enable ignored; the trigger load also requires converter_enable
// [R7] Flag held high starts nothing new
// [R8] Edges during conversion are ignored
// [R9] Software clears flag after each trigger
// [R10] Converter reads hidden shadow register
// [R11] Low write blocks updates until high
// [R12] Software writes low then high byte
// [R13] High write alone suffices for 8-bit
// [R14] Left adjust selects byte layout
// [R15] Left adjust acts at next high write
// [R16] Output enable routes result to pin
// [R17] Core code is ten bits wide
// [R18] Edge found against last cycle flag
module dtc_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register bus
  input wire dtc_pkg::dtc_apb_req_type apb_req,
  output dtc_pkg::dtc_apb_rsp_type apb_rsp,
  // Event flags, one per trigger source
  input wire logic [7:0] event_flags,
  // Converter core
  output dtc_pkg::dtc_core_type core
);

  localparam logic [4:0] CONV_CYCLES = 5'(`DTC_CONV_CYCLES);

  typedef struct packed {
    dtc_pkg::dtc_ctrl_type ctrl;
    logic [7:0] value_high_byte;
    logic [7:0] value_low_byte;
    logic [9:0] shadow;
    logic left_adjust_snap;
    logic low_pending;
    logic [7:0] flags_prev;
    dtc_pkg::dtc_conv_state_type state;
    logic [4:0] busy_cnt;
    logic start;
    logic [31:0] prdata;
    logic slverr;
  } dtc_state_type;

  dtc_state_type st_ff;
  dtc_state_type nxt_st;
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic hi_wr;
  logic lo_wr;
  logic ctrl_wr;
  logic sel_flag;
  logic sel_prev;
  logic trig_edge;
  logic trig_load;
  logic [9:0] manual_code;
  logic [9:0] auto_code;

  function automatic logic [9:0] dtc_assemble(
    input logic la,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    // Left adjust keeps the top eight code bits in the high byte
    if (la)
    begin
      return {hi, lo[7:6]}; // see [R14]
    end
    return {hi[1:0], lo}; // see [R14]
  endfunction : dtc_assemble

  // Release of reset is synchronised; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign wr = access && apb_req.pwrite;
  assign mapped = (apb_req.paddr == `DTC_OFS_CTRL) ||
                  (apb_req.paddr == `DTC_OFS_HIGH) ||
                  (apb_req.paddr == `DTC_OFS_LOW) ||
                  (apb_req.paddr == `DTC_OFS_STAT);
  assign hi_wr = wr && (apb_req.paddr == `DTC_OFS_HIGH);
  assign lo_wr = wr && (apb_req.paddr == `DTC_OFS_LOW);
  assign ctrl_wr = wr && (apb_req.paddr == `DTC_OFS_CTRL);

  // Selected flag and its copy from the previous cycle
  assign sel_flag = event_flags[st_ff.ctrl.trigger_select]; // see [R4]
  assign sel_prev = st_ff.flags_prev[st_ff.ctrl.trigger_select];
  assign trig_edge = sel_flag && !sel_prev; // see [R6] see [R18]

  // A pending low byte blocks the trigger path until the high write
  assign trig_load = st_ff.ctrl.auto_trigger_enable && // see [R5]
                     st_ff.ctrl.converter_enable && // see [R1]
                     trig_edge && // see [R2] see [R7]
                     (st_ff.state == dtc_pkg::DTC_IDLE) && // see [R8]
                     !st_ff.low_pending; // see [R11] see [R13]

  assign manual_code = dtc_assemble(st_ff.ctrl.left_adjust,
                                    apb_req.pwdata[7:0],
                                    st_ff.value_low_byte); // see [R15]
  assign auto_code = dtc_assemble(st_ff.left_adjust_snap,
                                  st_ff.value_high_byte,
                                  st_ff.value_low_byte);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.flags_prev = event_flags; // see [R18]
    // Read data is sampled in the setup phase so pready can be constant
    if (setup)
    begin
      nxt_st.slverr = !mapped;
      unique case (apb_req.paddr)
        `DTC_OFS_CTRL: nxt_st.prdata = {24'h000000, st_ff.ctrl};
        `DTC_OFS_HIGH: nxt_st.prdata = {24'h000000, st_ff.value_high_byte};
        `DTC_OFS_LOW: nxt_st.prdata = {24'h000000, st_ff.value_low_byte};
        // The shadow itself stays hidden from software
        `DTC_OFS_STAT: nxt_st.prdata = {20'h00000, st_ff.low_pending,
                                        st_ff.state, 10'h000}; // see [R10]
        default: nxt_st.prdata = 32'h00000000;
      endcase
    end
    if (ctrl_wr)
    begin
      nxt_st.ctrl = apb_req.pwdata[7:0];
      nxt_st.ctrl.rsvd = 1'b0;
    end
    if (lo_wr)
    begin
      nxt_st.value_low_byte = apb_req.pwdata[7:0];
      nxt_st.low_pending = 1'b1; // see [R11] see [R12]
    end
    // Conversion timer; a new trigger cannot restart it
    unique case (st_ff.state)
      dtc_pkg::DTC_IDLE:
      begin
        if (trig_load)
        begin
          nxt_st.state = dtc_pkg::DTC_BUSY;
          nxt_st.busy_cnt = CONV_CYCLES - 5'h01;
        end
      end
      dtc_pkg::DTC_BUSY:
      begin
        if (st_ff.busy_cnt == 5'h00)
        begin
          nxt_st.state = dtc_pkg::DTC_IDLE;
        end
        else
        begin
          nxt_st.busy_cnt = st_ff.busy_cnt - 5'h01;
        end
      end
    endcase
    if (trig_load)
    begin
      nxt_st.shadow = auto_code; // see [R2] see [R10]
      nxt_st.start = 1'b1;
    end
    // The high write wins over a same-cycle trigger for the data bytes
    if (hi_wr)
    begin
      nxt_st.value_high_byte = apb_req.pwdata[7:0];
      nxt_st.low_pending = 1'b0; // see [R11]
      nxt_st.left_adjust_snap = st_ff.ctrl.left_adjust; // see [R15]
      if (!st_ff.ctrl.auto_trigger_enable)
      begin
        nxt_st.shadow = manual_code; // see [R3] see [R13]
        // A write during a conversion updates the code but starts nothing
        if (st_ff.ctrl.converter_enable && // see [R1]
            (st_ff.state == dtc_pkg::DTC_IDLE))
        begin
          nxt_st.start = 1'b1;
          nxt_st.state = dtc_pkg::DTC_BUSY;
          nxt_st.busy_cnt = CONV_CYCLES - 5'h01;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      st_ff.ctrl <= `DTC_RST_CTRL;
      st_ff.value_high_byte <= `DTC_RST_HIGH;
      st_ff.value_low_byte <= `DTC_RST_LOW;
      st_ff.shadow <= 10'h000;
      st_ff.left_adjust_snap <= 1'b0;
      st_ff.low_pending <= 1'b0;
      st_ff.flags_prev <= 8'h00;
      st_ff.state <= dtc_pkg::DTC_IDLE;
      st_ff.busy_cnt <= 5'h00;
      st_ff.start <= 1'b0;
      st_ff.prdata <= 32'h00000000;
      st_ff.slverr <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Zero-wait slave: every access phase completes in one cycle
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.prdata = st_ff.prdata;
  assign apb_rsp.pslverr = access && st_ff.slverr;

  assign core.code = st_ff.shadow; // see [R10] see [R17]
  assign core.enable = st_ff.ctrl.converter_enable; // see [R1]
  assign core.start = st_ff.start;
  assign core.busy = (st_ff.state == dtc_pkg::DTC_BUSY);
  // Without enable the pin driver stays off even if routing is set
  assign core.analog_out_pin = st_ff.ctrl.pin_output_enable &&
                               st_ff.ctrl.converter_enable; // see [R16]

  default clocking dtc_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_sync_ff);

  sequence s_auto_edge;
    st_ff.ctrl.auto_trigger_enable && st_ff.ctrl.converter_enable &&
    trig_edge && (st_ff.state == dtc_pkg::DTC_IDLE) &&
    !st_ff.low_pending;
  endsequence

  sequence s_loaded_auto;
    core.start && core.busy && (core.code == $past(auto_code));
  endsequence

  a_auto_trig_load: assert property (s_auto_edge |=> s_loaded_auto) // see [R2]
    else $error("auto trigger edge did not load the shadow");

  a_manual_load: assert property ( // see [R3]
    hi_wr && !st_ff.ctrl.auto_trigger_enable |=>
      core.code == dtc_assemble($past(st_ff.ctrl.left_adjust),
                                $past(apb_req.pwdata[7:0]),
                                $past(st_ff.value_low_byte)))
    else $error("high write in manual mode did not load the shadow");

  a_no_edge_start: assert property ( // see [R7]
    st_ff.ctrl.auto_trigger_enable && !trig_edge |=> !core.start)
    else $error("start without a fresh trigger edge");

  a_busy_ignore: assert property ( // see [R8]
    core.start |=> (!core.start && core.busy)[*8])
    else $error("trigger accepted during a conversion");

  a_low_blocks: assert property ( // see [R11]
    st_ff.low_pending && !hi_wr |=> $stable(core.code))
    else $error("shadow changed while the low byte was pending");

  a_edge_source: assert property ( // see [R18]
    core.start && st_ff.ctrl.auto_trigger_enable |->
      $past(trig_edge))
    else $error("auto start without a registered flag edge");

  a_disabled_idle: assert property ( // see [R1]
    !st_ff.ctrl.converter_enable && !ctrl_wr |=> !core.start)
    else $error("conversion started while disabled");

  a_pin_route: assert property ( // see [R16]
    core.analog_out_pin |-> st_ff.ctrl.pin_output_enable &&
      core.enable)
    else $error("pin driven without output enable");

  a_auto_hold: assert property ( // see [R2]
    hi_wr && st_ff.ctrl.auto_trigger_enable && !trig_load |=>
      $stable(core.code))
    else $error("high write loaded shadow in auto trigger mode");

  a_manual_start: assert property ( // see [R3]
    hi_wr && !st_ff.ctrl.auto_trigger_enable &&
      st_ff.ctrl.converter_enable && !core.busy |=> core.start && core.busy)
    else $error("manual high write did not start a conversion");

  a_busy_end: assert property ( // see [R8]
    core.start |-> ##10 !core.busy)
    else $error("conversion did not end after its fixed length");

endmodule : dtc_ctrl

// *** testbench/dtc_src_model.sv ***
// Event sources: eight level interrupt flags feeding the trigger select
// Assumes the bench commands raise and clear right after a rising edge
`timescale 1ns/1ns
module dtc_src_model (
  // Clock
  input wire logic mclk,
  // Commands from the bench
  input wire logic [2:0] ev_idx,
  input wire logic ev_set,
  input wire logic ev_clr,
  // Flags seen by the block
  output logic [7:0] event_flags
);
  initial event_flags = 8'h00;
  // Flags are sticky like real interrupt flags; only a clear drops them
  always @(posedge mclk)
  begin
    if (ev_clr)
      event_flags <= 8'h00;
    else if (ev_set)
      event_flags[ev_idx] <= 1'b1;
  end
endmodule : dtc_src_model

// *** testbench/tb.sv ***
// Self-checking bench for the converter control block
// Assumes zero-wait APB answers and a ten-cycle conversion
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("mismatch %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tb;
  logic mclk;
  logic rst_b;
  dtc_pkg::dtc_apb_req_type req;
  dtc_pkg::dtc_apb_rsp_type rsp;
  dtc_pkg::dtc_core_type core;
  logic [7:0] flags;
  logic [2:0] ev_idx;
  logic ev_set;
  logic ev_clr;
  logic [31:0] rd;
  logic err;
  logic seen;
  int error_cnt;
  int num_checks;
  dtc_ctrl dut (.mclk(mclk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
    .event_flags(flags), .core(core));
  dtc_src_model src (.mclk(mclk), .ev_idx(ev_idx), .ev_set(ev_set),
    .ev_clr(ev_clr), .event_flags(flags));
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    req <= '{1'b1, 1'b0, wr, a, {24'h000000, d}};
    @(posedge mclk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1)
    begin
      error_cnt++;
      results();
    end
  endtask : apb
  // Sampled on the falling edge so the one-cycle start pulse has settled
  task automatic wait_start(input int lim);
    seen = 1'b0;
    repeat (lim)
    begin
      @(negedge mclk);
      if (core.start === 1'b1)
        seen = 1'b1;
    end
  endtask : wait_start
  task automatic pulse(input logic clr, input logic [2:0] idx);
    @(posedge mclk);
    ev_idx <= idx;
    ev_set <= ~clr;
    ev_clr <= clr;
    @(posedge mclk);
    ev_set <= 1'b0;
    ev_clr <= 1'b0;
  endtask : pulse
  task automatic t_regs();
    apb(1'b0, 8'h00, 8'h00);
    `CHK("ctrl rst", 32'h0, rd);
    apb(1'b0, 8'h04, 8'h00);
    `CHK("high rst", 32'h0, rd);
    apb(1'b0, 8'h08, 8'h00);
    `CHK("low rst", 32'h0, rd);
    apb(1'b0, 8'h10, 8'h00);
    `CHK("unmapped err", 1'b1, err);
    apb(1'b1, 8'h00, 8'hFF);
    apb(1'b0, 8'h00, 8'h00);
    `CHK("ctrl rb", 32'hF7, rd);
    apb(1'b1, 8'h00, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_manual();
    apb(1'b1, 8'h00, 8'h71);
    apb(1'b1, 8'h08, 8'h5A);
    `CHK("low only", 10'h000, core.code);
    apb(1'b0, 8'h0C, 8'h00);
    `CHK("stat pending", 32'h800, rd);
    apb(1'b1, 8'h04, 8'h02);
    wait_start(3);
    `CHK("man start", 1'b1, seen);
    `CHK("man code", 10'h25A, core.code);
    pulse(1'b0, 3'h7);
    wait_start(5);
    `CHK("sel ignored", 1'b0, seen);
    pulse(1'b1, 3'h0);
    `CHK("enable", 1'b1, core.enable);
    `CHK("pin off", 1'b0, core.analog_out_pin);
    apb(1'b1, 8'h00, 8'h07);
    // Let the register update of the access edge settle first
    @(negedge mclk);
    `CHK("pin on", 1'b1, core.analog_out_pin);
    `CHK("la late", 10'h25A, core.code);
    apb(1'b1, 8'h08, 8'hC0);
    apb(1'b1, 8'h04, 8'hAB);
    wait_start(3);
    `CHK("left code", 10'h2AF, core.code);
    apb(1'b0, 8'h0C, 8'h00);
    `CHK("stat busy", 32'h400, rd);
    apb(1'b1, 8'h04, 8'h80);
    wait_start(3);
    `CHK("8bit code", 10'h203, core.code);
    `CHK("busy no start", 1'b0, seen);
    apb(1'b1, 8'h00, 8'h00);
    @(negedge mclk);
    `CHK("disable", 1'b0, core.enable);
    $display("test manual done");
  endtask : t_manual
  task automatic t_auto(input logic [2:0] s);
    logic [9:0] old;
    old = core.code;
    apb(1'b1, 8'h00, {1'b1, s, 4'h1});
    apb(1'b1, 8'h08, {5'h02, s});
    apb(1'b1, 8'h04, 8'h01);
    wait_start(3);
    `CHK("no hi load", old, core.code);
    pulse(1'b0, s ^ 3'h1);
    wait_start(4);
    `CHK("other flag", 1'b0, seen);
    pulse(1'b0, s);
    wait_start(4);
    `CHK("trig start", 1'b1, seen);
    `CHK("trig code", {5'h02, s} | 10'h100, core.code);
    `CHK("busy", 1'b1, core.busy);
    pulse(1'b1, s);
    pulse(1'b0, s);
    wait_start(14);
    `CHK("no retrig", 1'b0, seen);
    pulse(1'b1, s);
  endtask : t_auto
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    req = '0;
    ev_idx = 3'h0;
    ev_set = 1'b0;
    ev_clr = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    rst_b = 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_manual();
    for (int i = 0; i < 8; i++)
      t_auto(i[2:0]);
    $display("test auto done");
    results();
  end
endmodule : tb
